// [dv/dcpb_bank_props.sv]
// Concurrent checks on the common parameter bank ports.
// Assumes one clock domain and the default limit parameters of the bank.
`timescale 1ns/100ps
`include "dcpb_defs.svh"

module dcpb_bank_props
    import dcpb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input dcpb_req_type req,
    input dcpb_drive_flags_type driveFlags,
    input dcpb_trip_type tripFlags,
    input dcpb_rsp_type rsp,
    input dcpb_cmd_type cmd,
    input logic [15:0] speedSetpoint,
    input logic writeUnlocked
);
    logic [4:0] runLast_reg;
    logic runWr_reg;
    logic [15:0] statusQ_reg;
    wire logic runWr = req.valid && req.write && req.addr == `DCPB_OFS_RUNCTL;

    // Shadow of the last run word write, for edge expectations
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            runLast_reg <= 5'h00;
            runWr_reg <= 1'b0;
            statusQ_reg <= 16'h0000;
        end else begin
            runWr_reg <= runWr;
            statusQ_reg <= {1'b0, driveFlags[13:9], 1'b0, driveFlags[8:0]};
            if (runWr) begin
                runLast_reg <= req.data[4:0];
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_read(logic [15:0] a);
        req.valid && !req.write && req.addr == a;
    endsequence
    sequence s_fwd_rise;
        runWr && req.data[1] && !runLast_reg[1];
    endsequence
    sequence s_fwd_pulse;
        cmd.forwardReq ##1 !cmd.forwardReq;
    endsequence

    a_fwd_edge_pulse: assert property (s_fwd_rise |=> s_fwd_pulse)
        else $error("forward pulse missing after rising run bit");
    a_cmd_has_cause: assert property (cmd != 5'h00 |-> runWr_reg)
        else $error("action pulse without a run word write");
    a_rsp_follows: assert property (req.valid |=> rsp.valid)
        else $error("request not answered in one cycle");
    a_bad_addr_nak: assert property (
        req.valid && req.addr > `DCPB_OFS_LAST
        |=> rsp.nak && rsp.errCode == `DCPB_ERR_BAD_ADDR)
        else $error("unknown address not refused");
    a_ro_write_nak: assert property (
        req.valid && req.write
        && (req.addr <= `DCPB_OFS_FIRMWARE
        || (req.addr >= `DCPB_OFS_CURRENT && req.addr <= `DCPB_OFS_LAST))
        |=> rsp.nak && rsp.errCode == `DCPB_ERR_WRITE_PROHIB)
        else $error("read-only write not refused");
    a_locked_nak: assert property (
        req.valid && req.write && !writeUnlocked
        && (req.addr == `DCPB_OFS_SPEED || req.addr == `DCPB_OFS_RAMPUP
        || req.addr == `DCPB_OFS_RAMPDN)
        |=> rsp.nak && rsp.errCode == `DCPB_ERR_WRITE_PROHIB)
        else $error("locked write not refused");
    a_speed_range: assert property (
        req.valid && req.write && writeUnlocked
        && req.addr == `DCPB_OFS_SPEED
        && (req.data < `DCPB_SPEED_MIN || req.data > `DCPB_SPEED_MAX)
        |=> rsp.nak && rsp.errCode == `DCPB_ERR_DATA_RANGE
        && speedSetpoint == $past(speedSetpoint))
        else $error("out of range setpoint not refused");
    a_status_map: assert property (
        s_read(`DCPB_OFS_STATE) |=> rsp.data == statusQ_reg)
        else $error("status word mapping wrong");
    a_trip_map: assert property (
        s_read(`DCPB_OFS_FAULT) |=> rsp.data == $past(tripFlags))
        else $error("trip word mapping wrong");
    a_nak_data_zero: assert property (
        rsp.valid && rsp.nak |-> rsp.data == 16'h0000)
        else $error("refusal carries data");
endmodule : dcpb_bank_props

bind dcpb_bank dcpb_bank_props u_props (.clk(clk), .rst_b(rst_b), .req(req),
    .driveFlags(driveFlags), .tripFlags(tripFlags), .rsp(rsp), .cmd(cmd),
    .speedSetpoint(speedSetpoint), .writeUnlocked(writeUnlocked));

// [dv/dcpb_master_model.sv]
// Serial master stand-in: one word request per call of access.
// Assumes the bank answers within a few cycles of the taking edge.
`timescale 1ns/100ps

module dcpb_master_model
    import dcpb_pkg::*;
(
    input wire logic clk,
    input dcpb_rsp_type rsp,
    output dcpb_req_type req
);
    initial req = '0;

    // Held up to the taking edge; released fields show the inverse, never stale data
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
        output dcpb_rsp_type r);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{valid: 1'b1, write: w, addr: a, data: d};
        @(posedge clk);
        req <= '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
        #1;
        while (rsp.valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        r = rsp;
    endtask : access
endmodule : dcpb_master_model

// [dv/tb_drive_common_parameter_bank.sv]
// Self-checking bench for the common parameter bank.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`include "dcpb_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
$display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_drive_common_parameter_bank
    import dcpb_pkg::*;
();
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    int failures = 0;
    int n_tests = 0;
    dcpb_req_type req;
    dcpb_rsp_type rsp;
    dcpb_rsp_type r;
    dcpb_drive_flags_type driveFlags = '0;
    dcpb_trip_type tripFlags = '0;
    dcpb_monitor_type monitors = '0;
    logic [1:0] runSource = 2'h0;
    logic [4:0] speedSource = 5'h00;
    logic [3:0] digitalInputs = 4'h0;
    dcpb_cmd_type cmd;
    logic [15:0] speedSetpoint;
    logic [15:0] rampUpTime;
    logic [15:0] rampDownTime;
    logic writeUnlocked;

    // 20 MHz clock
    always #25 clk = ~clk;

    dcpb_bank uut (.clk(clk), .rst_b(rst_b), .req(req), .driveFlags(driveFlags),
        .tripFlags(tripFlags), .monitors(monitors), .runSource(runSource),
        .speedSource(speedSource), .digitalInputs(digitalInputs), .rsp(rsp), .cmd(cmd),
        .speedSetpoint(speedSetpoint), .rampUpTime(rampUpTime),
        .rampDownTime(rampDownTime), .writeUnlocked(writeUnlocked));
    dcpb_master_model master (.clk(clk), .rsp(rsp), .req(req));

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        master.access(1'b0, a, 16'h0000, r);
        `CHK("read valid", 1'b1, r.valid)
        `CHK("read ack", 1'b0, r.nak)
        `CHK("read code", 16'h0000, r.errCode)
        `CHK("read data", e, r.data)
    endtask : rd

    // Write ack returns the word as it stood before the write
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [15:0] old);
        master.access(1'b1, a, d, r);
        `CHK("write valid", 1'b1, r.valid)
        `CHK("write ack", 1'b0, r.nak)
        `CHK("write old", old, r.data)
    endtask : wr

    task automatic nak(input logic w, input logic [15:0] a, input logic [15:0] d,
        input logic [15:0] code);
        master.access(w, a, d, r);
        `CHK("nak valid", 1'b1, r.valid)
        `CHK("nak flag", 1'b1, r.nak)
        `CHK("nak code", code, r.errCode)
        `CHK("nak data", 16'h0000, r.data)
    endtask : nak

    function automatic logic [15:0] runExp(input logic [2:0] b);
        return {3'h0, speedSource, runSource, 3'h0, b};
    endfunction : runExp

    // Requests wait until the synchronised reset has let go
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset

    task automatic t_defaults();
        for (int i = 0; i < 4; i++) rd(i[15:0], 16'h00E1 + 16'(i));
        rd(`DCPB_OFS_PROTECT, 16'h0000);
        rd(`DCPB_OFS_SPEED, 16'h0032);
        rd(`DCPB_OFS_RAMPUP, 16'h0032);
        rd(`DCPB_OFS_RAMPDN, 16'h0032);
        `CHK("unlocked", 1'b0, writeUnlocked)
        $display("test defaults done");
    endtask : t_defaults

    // Lock beats range check; lock word itself is range checked
    task automatic t_lock();
        nak(1'b1, `DCPB_OFS_SPEED, 16'h0031, `DCPB_ERR_WRITE_PROHIB);
        nak(1'b1, `DCPB_OFS_PROTECT, 16'h0002, `DCPB_ERR_DATA_RANGE);
        wr(`DCPB_OFS_PROTECT, 16'h0001, 16'h0000);
        `CHK("unlocked", 1'b1, writeUnlocked)
        $display("test lock done");
    endtask : t_lock

    task automatic t_ranges();
        nak(1'b1, `DCPB_OFS_SPEED, 16'h0031, `DCPB_ERR_DATA_RANGE);
        nak(1'b1, `DCPB_OFS_SPEED, 16'h1771, `DCPB_ERR_DATA_RANGE);
        wr(`DCPB_OFS_SPEED, 16'h1770, 16'h0032);
        `CHK("setpoint", 16'h1770, speedSetpoint)
        nak(1'b1, `DCPB_OFS_RAMPUP, 16'h1771, `DCPB_ERR_DATA_RANGE);
        wr(`DCPB_OFS_RAMPUP, 16'h1770, 16'h0032);
        wr(`DCPB_OFS_RAMPDN, 16'h0000, 16'h0032);
        `CHK("ramp up", 16'h1770, rampUpTime)
        `CHK("ramp down", 16'h0000, rampDownTime)
        $display("test ranges done");
    endtask : t_ranges

    task automatic t_refuse();
        for (int i = 0; i <= 16; i++)
            if (i < 4 || i > 8) nak(1'b1, i[15:0], 16'h1234, `DCPB_ERR_WRITE_PROHIB);
        nak(1'b0, 16'h0011, 16'h0000, `DCPB_ERR_BAD_ADDR);
        nak(1'b1, 16'hFFFF, 16'h0001, `DCPB_ERR_BAD_ADDR);
        $display("test refusals done");
    endtask : t_refuse

    // Edges count against the last write, not against the read-back
    task automatic t_run();
        logic [4:0] codes [8] = '{5'h00, 5'h02, 5'h08, 5'h11, 5'h12, 5'h13, 5'h14, 5'h1F};
        // Sources settle an edge before the expectation is formed
        @(posedge clk);
        runSource <= 2'h3;
        speedSource <= 5'h13;
        @(posedge clk);
        wr(`DCPB_OFS_RUNCTL, 16'h0002, runExp(3'h0));
        `CHK("fwd pulse", 5'h08, cmd)
        wr(`DCPB_OFS_RUNCTL, 16'h0002, runExp(3'h2));
        `CHK("no pulse", 5'h00, cmd)
        wr(`DCPB_OFS_RUNCTL, 16'hE03D, runExp(3'h2));
        `CHK("edge pulses", 5'h17, cmd)
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            runSource <= k[1:0];
            speedSource <= codes[k];
            @(posedge clk);
            rd(`DCPB_OFS_RUNCTL, runExp(3'h5));
        end
        $display("test run word done");
    endtask : t_run

    // Complementary patterns reach every status, trip and monitor bit
    task automatic t_status();
        logic [13:0] p;
        logic [15:0] t;
        logic [79:0] mon;
        for (int j = 0; j < 2; j++) begin
            p = j ? 14'h1555 : 14'h2AAA;
            t = j ? 16'h5A5A : 16'hA5A5;
            mon = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555} ^ {80{j[0]}};
            @(posedge clk);
            driveFlags <= p;
            tripFlags <= t;
            digitalInputs <= p[3:0];
            monitors <= mon;
            @(posedge clk);
            rd(`DCPB_OFS_STATE, {1'b0, p[13:9], 1'b0, p[8:0]});
            rd(`DCPB_OFS_FAULT, t);
            rd(`DCPB_OFS_INPUTS, {12'h000, p[3:0]});
            for (int m = 0; m < 5; m++) rd(16'h0009 + 16'(m), mon[79 - 16 * m -: 16]);
        end
        $display("test status done");
    endtask : t_status

    task automatic conclude();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // Second reset must bring back the default lock, setpoint and ramp words
    initial begin
        do_reset();
        t_defaults();
        t_lock();
        t_ranges();
        t_refuse();
        t_run();
        t_status();
        do_reset();
        t_defaults();
        conclude();
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        #(50 * 20000);
        failures++;
        conclude();
    end
endmodule : tb_drive_common_parameter_bank

// [src/dcpb_access_check.sv]
// Address and write-permission check for one word access.
// Purely combinational; the bank registers its verdict.
`timescale 1ns/100ps
`include "dcpb_defs.svh"

module dcpb_access_check
    import dcpb_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic write,
    input wire logic unlocked,
    output dcpb_access_type accessClass
);

    // Lockable words only; run control stays writable so a locked
    // drive can still be stopped from the link
    function automatic logic isLockable(input logic [15:0] a);
        isLockable = (a == `DCPB_OFS_SPEED) || (a == `DCPB_OFS_RAMPUP)
            || (a == `DCPB_OFS_RAMPDN);
    endfunction : isLockable

    function automatic logic isWritable(input logic [15:0] a);
        isWritable = isLockable(a) || (a == `DCPB_OFS_PROTECT)
            || (a == `DCPB_OFS_RUNCTL);
    endfunction : isWritable

    // Priority: bad address, read only, lock
    always_comb begin
        accessClass = DCPB_ACC_OK;
        if (addr > `DCPB_OFS_LAST) begin
            accessClass = DCPB_ACC_BAD_ADDR;
        end else if (write && !isWritable(addr)) begin
            accessClass = DCPB_ACC_READ_ONLY;
        end else if (write && isLockable(addr) && !unlocked) begin
            accessClass = DCPB_ACC_LOCKED;
        end
    end

endmodule : dcpb_access_check

// [src/dcpb_bank.sv]
// Common parameter bank of a motor drive: one word access per request,
// answered one cycle later with an ack or a nak code.
// Assumes a frame parser in front that splits multi-word frames into
// single word requests and builds the reply frame from each answer.
//
// Operation
// - Run word 0->1 on bits 0-4 acts
// - Run word bits 6-7 show run source
// - Run word bits 8-12 show frequency source
// - Status bits 0-3: stop, fwd, rev, trip
// - Status bits 4-8 ramp and braking, 9 unused
// - Status bits 10-14 brake, commands, remote
// - Trip bits 0-7 flag the first eight faults
// - Trip bits 8-15 flag the remaining faults
// - Same addresses and meanings for every model
// - Read-only or blocked write gets write-prohibited
// - Out-of-range data gets data-range error
// - Unknown address gets bad-address error
// - Written values revert on reset
`timescale 1ns/100ps
`include "dcpb_defs.svh"

module dcpb_bank
    import dcpb_pkg::*;
#(
    // Identity words, values arbitrary
    parameter logic [15:0] MODEL_CODE = 16'h00E1,
    parameter logic [15:0] RATING_CODE = 16'h00E2,
    parameter logic [15:0] SUPPLY_CLASS = 16'h00E3,
    parameter logic [15:0] FIRMWARE_CODE = 16'h00E4,
    // Setpoint limits in 0.01 Hz, ramp limit in 0.1 s
    parameter logic [15:0] SPEED_MIN = `DCPB_SPEED_MIN,
    parameter logic [15:0] SPEED_MAX = `DCPB_SPEED_MAX,
    parameter logic [15:0] RAMP_MAX = `DCPB_RAMP_MAX,
    parameter logic [15:0] RAMP_RESET = `DCPB_RAMP_RST
) (
    input wire logic clk,
    input wire logic rst_b,
    input dcpb_req_type req,
    input dcpb_drive_flags_type driveFlags,
    input dcpb_trip_type tripFlags,
    input dcpb_monitor_type monitors,
    input wire logic [1:0] runSource,
    input wire logic [4:0] speedSource,
    input wire logic [3:0] digitalInputs,
    output dcpb_rsp_type rsp,
    output dcpb_cmd_type cmd,
    output logic [15:0] speedSetpoint,
    output logic [15:0] rampUpTime,
    output logic [15:0] rampDownTime,
    output logic writeUnlocked
);

    logic [1:0] rstSync_reg;
    logic rstLocal_b;
    dcpb_bank_state_type state_reg;
    dcpb_bank_state_type state_next;
    dcpb_access_type accessClass;
    logic runWrite;
    logic [`DCPB_RUN_TRIG_W-1:0] runRise;
    logic [15:0] readWord;
    logic inRange;

    // Reset released through two flops, asserted at once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end

    assign rstLocal_b = rstSync_reg[1];

    // Status word with the unused bits 9 and 15 held at zero
    function automatic logic [15:0] packStatus(input dcpb_drive_flags_type f);
        packStatus = {1'b0, f.remoteSpeedSource, f.remoteRunStop,
            f.revRunCommand, f.fwdRunCommand, f.brakeOpen, 1'b0,
            f.stopping, f.dcBraking, f.speedArrival, f.decelerating,
            f.accelerating, f.faultTrip, f.runningReverse,
            f.runningForward, f.stopped};
    endfunction : packStatus

    // Run command read-back; trigger bits 3-4 are write only
    function automatic logic [15:0] packRun(
        input logic [`DCPB_RUN_TRIG_W-1:0] last,
        input logic [1:0] src,
        input logic [4:0] fsrc
    );
        packRun = 16'h0000;
        packRun[`DCPB_RUN_STOP] = last[`DCPB_RUN_STOP];
        packRun[`DCPB_RUN_FWD] = last[`DCPB_RUN_FWD];
        packRun[`DCPB_RUN_REV] = last[`DCPB_RUN_REV];
        packRun[`DCPB_RUN_SRC_LSB +: 2] = src;
        packRun[`DCPB_RUN_FSRC_LSB +: 5] = fsrc;
    endfunction : packRun

    // Address and permission check
    dcpb_access_check u_check (
        .addr(req.addr),
        .write(req.write),
        .unlocked(state_reg.protect[0]),
        .accessClass(accessClass)
    );

    assign runWrite = req.valid && req.write
        && (req.addr == `DCPB_OFS_RUNCTL) && (accessClass == DCPB_ACC_OK);

    // Edges are taken against the last word written, not the
    // read-back, so a repeated write of 1 does not re-trigger
    dcpb_edge_detect #(
        .WIDTH(`DCPB_RUN_TRIG_W)
    ) u_edge (
        .prevBits(state_reg.runLast),
        .newBits(req.data[`DCPB_RUN_TRIG_W-1:0]),
        .strobe(runWrite),
        .riseBits(runRise)
    );

    // Read multiplexer over the whole common area
    // fixed map
    always_comb begin
        readWord = 16'h0000;
        unique case (req.addr)
            `DCPB_OFS_MODEL: readWord = MODEL_CODE;
            `DCPB_OFS_RATING: readWord = RATING_CODE;
            `DCPB_OFS_SUPPLY: readWord = SUPPLY_CLASS;
            `DCPB_OFS_FIRMWARE: readWord = FIRMWARE_CODE;
            `DCPB_OFS_PROTECT: readWord = state_reg.protect;
            `DCPB_OFS_SPEED: readWord = state_reg.speed;
            `DCPB_OFS_RUNCTL: readWord = packRun(state_reg.runLast,
                runSource, speedSource);
            `DCPB_OFS_RAMPUP: readWord = state_reg.rampUp;
            `DCPB_OFS_RAMPDN: readWord = state_reg.rampDown;
            `DCPB_OFS_CURRENT: readWord = monitors.loadCurrent;
            `DCPB_OFS_FREQ: readWord = monitors.driveFrequency;
            `DCPB_OFS_VOLT: readWord = monitors.driveVoltage;
            `DCPB_OFS_BUSV: readWord = monitors.busVoltage;
            `DCPB_OFS_POWER: readWord = monitors.drivePower;
            `DCPB_OFS_STATE: readWord = packStatus(driveFlags);
            `DCPB_OFS_FAULT: readWord = tripFlags;
            `DCPB_OFS_INPUTS: readWord = {12'h000, digitalInputs};
            default: readWord = 16'h0000;
        endcase
    end

    // Range of the data carried by a write
    // range limits
    always_comb begin
        inRange = 1'b1;
        unique case (req.addr)
            `DCPB_OFS_PROTECT: inRange = (req.data <= `DCPB_PROTECT_MAX);
            `DCPB_OFS_SPEED: inRange = (req.data >= SPEED_MIN)
                && (req.data <= SPEED_MAX);
            `DCPB_OFS_RAMPUP: inRange = (req.data <= RAMP_MAX);
            `DCPB_OFS_RAMPDN: inRange = (req.data <= RAMP_MAX);
            default: inRange = 1'b1;
        endcase
    end

    // Next state: answer every request one cycle later
    always_comb begin
        state_next = state_reg;
        state_next.rsp = '0;
        state_next.cmd = '0;
        if (req.valid) begin
            state_next.rsp.valid = 1'b1;
            unique case (accessClass)
                DCPB_ACC_BAD_ADDR: begin
                    state_next.rsp.nak = 1'b1;
                    state_next.rsp.errCode = `DCPB_ERR_BAD_ADDR;
                end
                DCPB_ACC_READ_ONLY, DCPB_ACC_LOCKED: begin
                    state_next.rsp.nak = 1'b1;
                    state_next.rsp.errCode = `DCPB_ERR_WRITE_PROHIB;
                end
                DCPB_ACC_OK: begin
                    // Ack carries the word as it stood before a write
                    state_next.rsp.data = readWord;
                    if (req.write && !inRange) begin
                        state_next.rsp.nak = 1'b1;
                        state_next.rsp.errCode = `DCPB_ERR_DATA_RANGE;
                        state_next.rsp.data = 16'h0000;
                    end else if (req.write) begin
                        unique case (req.addr)
                            `DCPB_OFS_PROTECT: state_next.protect = req.data;
                            `DCPB_OFS_SPEED: state_next.speed = req.data;
                            `DCPB_OFS_RAMPUP: state_next.rampUp = req.data;
                            `DCPB_OFS_RAMPDN: state_next.rampDown = req.data;
                            `DCPB_OFS_RUNCTL: state_next.runLast =
                                req.data[`DCPB_RUN_TRIG_W-1:0];
                            default: state_next.protect = state_reg.protect;
                        endcase
                    end
                end
            endcase
        end
        state_next.cmd.stopReq = runRise[`DCPB_RUN_STOP];
        state_next.cmd.forwardReq = runRise[`DCPB_RUN_FWD];
        state_next.cmd.reverseReq = runRise[`DCPB_RUN_REV];
        state_next.cmd.faultResetReq = runRise[`DCPB_RUN_FRESET];
        state_next.cmd.emergencyStopReq = runRise[`DCPB_RUN_ESTOP];
    end

    // State register; reset restores every written value
    // revert on reset
    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            state_reg.rsp <= '0;
            state_reg.cmd <= '0;
            state_reg.protect <= `DCPB_PROTECT_RST;
            state_reg.speed <= `DCPB_SPEED_MIN;
            state_reg.rampUp <= `DCPB_RAMP_RST;
            state_reg.rampDown <= `DCPB_RAMP_RST;
            state_reg.runLast <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    assign rsp = state_reg.rsp;
    assign cmd = state_reg.cmd;
    assign speedSetpoint = state_reg.speed;
    assign rampUpTime = state_reg.rampUp;
    assign rampDownTime = state_reg.rampDown;
    assign writeUnlocked = state_reg.protect[0];

endmodule : dcpb_bank

// [src/dcpb_defs.svh]
// Offsets, field positions, reset values and error codes of the
// common parameter bank. Included by the package and design modules.
`ifndef DCPB_DEFS_SVH
`define DCPB_DEFS_SVH

// Word addresses of the common area
`define DCPB_OFS_MODEL 16'h0000
`define DCPB_OFS_RATING 16'h0001
`define DCPB_OFS_SUPPLY 16'h0002
`define DCPB_OFS_FIRMWARE 16'h0003
`define DCPB_OFS_PROTECT 16'h0004
`define DCPB_OFS_SPEED 16'h0005
`define DCPB_OFS_RUNCTL 16'h0006
`define DCPB_OFS_RAMPUP 16'h0007
`define DCPB_OFS_RAMPDN 16'h0008
`define DCPB_OFS_CURRENT 16'h0009
`define DCPB_OFS_FREQ 16'h000A
`define DCPB_OFS_VOLT 16'h000B
`define DCPB_OFS_BUSV 16'h000C
`define DCPB_OFS_POWER 16'h000D
`define DCPB_OFS_STATE 16'h000E
`define DCPB_OFS_FAULT 16'h000F
`define DCPB_OFS_INPUTS 16'h0010
`define DCPB_OFS_LAST 16'h0010

// Run command word fields
`define DCPB_RUN_STOP 0
`define DCPB_RUN_FWD 1
`define DCPB_RUN_REV 2
`define DCPB_RUN_FRESET 3
`define DCPB_RUN_ESTOP 4
`define DCPB_RUN_SRC_LSB 6
`define DCPB_RUN_FSRC_LSB 8
`define DCPB_RUN_TRIG_W 5

// Reset values and limits
`define DCPB_PROTECT_RST 16'h0000
`define DCPB_PROTECT_MAX 16'h0001
`define DCPB_SPEED_MIN 16'h0032
`define DCPB_SPEED_MAX 16'h1770
`define DCPB_RAMP_RST 16'h0032
`define DCPB_RAMP_MAX 16'h1770

// Two-character negative answer codes
`define DCPB_ERR_WRITE_PROHIB 16'h574D
`define DCPB_ERR_DATA_RANGE 16'h4944
`define DCPB_ERR_BAD_ADDR 16'h4941

`endif

// [src/dcpb_edge_detect.sv]
// Rising-edge finder for written trigger bits: compares the word
// being written with the last one written. Combinational.
`timescale 1ns/100ps

module dcpb_edge_detect #(
    parameter int WIDTH = 5
) (
    input wire logic [WIDTH-1:0] prevBits,
    input wire logic [WIDTH-1:0] newBits,
    input wire logic strobe,
    output logic [WIDTH-1:0] riseBits
);

    // A bit acts only on a 0 to 1 step between two writes
    always_comb begin
        riseBits = strobe ? (newBits & ~prevBits) : '0;
    end

endmodule : dcpb_edge_detect

// [src/dcpb_pkg.sv]
// Types shared by the common parameter bank modules.
// Assumes dcpb_defs.svh is on the include path.
`include "dcpb_defs.svh"

package dcpb_pkg;

    // One word request from the frame parser
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } dcpb_req_type;

    // Answer: ack with data, or nak with a two-character code
    typedef struct packed {
        logic valid;
        logic nak;
        logic [15:0] errCode;
        logic [15:0] data;
    } dcpb_rsp_type;

    // Live drive state, bit 9 and bit 15 are not carried
    typedef struct packed {
        logic remoteSpeedSource;
        logic remoteRunStop;
        logic revRunCommand;
        logic fwdRunCommand;
        logic brakeOpen;
        logic stopping;
        logic dcBraking;
        logic speedArrival;
        logic decelerating;
        logic accelerating;
        logic faultTrip;
        logic runningReverse;
        logic runningForward;
        logic stopped;
    } dcpb_drive_flags_type;

    // Trip word, MSB first so it casts straight to the register
    typedef struct packed {
        logic undervoltageTrip;
        logic driveOverloadTrip;
        logic phaseLoss;
        logic fanFault;
        logic parameterStoreError;
        logic externalTripSecond;
        logic hardwareDiagnosisFault;
        logic overloadTrip;
        logic motorOverheatTrip;
        logic driveOverheatTrip;
        logic groundFaultTrip;
        logic currentLimitTrip;
        logic outputBlock;
        logic externalTripFirst;
        logic overvoltageTrip;
        logic overcurrentTrip;
    } dcpb_trip_type;

    // Output monitors
    typedef struct packed {
        logic [15:0] loadCurrent;
        logic [15:0] driveFrequency;
        logic [15:0] driveVoltage;
        logic [15:0] busVoltage;
        logic [15:0] drivePower;
    } dcpb_monitor_type;

    // One-cycle action pulses from the run command word
    typedef struct packed {
        logic stopReq;
        logic forwardReq;
        logic reverseReq;
        logic faultResetReq;
        logic emergencyStopReq;
    } dcpb_cmd_type;

    // Outcome of the address and access check
    typedef enum logic [1:0] {
        DCPB_ACC_OK = 2'b00,
        DCPB_ACC_READ_ONLY = 2'b01,
        DCPB_ACC_LOCKED = 2'b10,
        DCPB_ACC_BAD_ADDR = 2'b11
    } dcpb_access_type;

    // Whole state of the bank
    typedef struct packed {
        dcpb_rsp_type rsp;
        dcpb_cmd_type cmd;
        logic [15:0] protect;
        logic [15:0] speed;
        logic [15:0] rampUp;
        logic [15:0] rampDown;
        logic [`DCPB_RUN_TRIG_W-1:0] runLast;
    } dcpb_bank_state_type;

endpackage : dcpb_pkg
